// *** design/eio_pad_ctl.sv ***
// file: per-pin pad control, turns direction, style and level into
// drive enables and pull requests
// assumes: pad cell resolves the wire; segment share handled here
`timescale 1ns/1ps
module eio_pad_ctl (
  input wire logic dir_in,
  input wire logic [1:0] style_in,
  input wire logic level_in,
  input wire logic seg_sel_in,
  input wire logic seg_val_in,
  output logic pin_out,
  output logic pin_oe_out,
  output logic pull_up_out,
  output logic pull_dn_out
);
  import eio_pkg::*;

  // drive decode per style, segment driver takes the pin when chosen
  always_comb
  begin
    pin_out = level_in;
    pin_oe_out = 1'b0;
    pull_up_out = 1'b0;
    pull_dn_out = 1'b0;
    if (seg_sel_in)
    begin
      pin_out = seg_val_in;
      pin_oe_out = 1'b1;
    end
    else if (dir_in == EIO_DIR_OUT)
    begin
      case (style_in)
        EIO_STY_HIZ: pin_oe_out = 1'b0;
        EIO_STY_PCH: pin_oe_out = level_in; // drives high only
        EIO_STY_NCH: pin_oe_out = ~level_in; // drives low only
        EIO_STY_CMOS: pin_oe_out = 1'b1;
        default: pin_oe_out = 1'b0;
      endcase
    end
    else
    begin
      pull_dn_out = (style_in == EIO_IN_PULLDN);
      pull_up_out = (style_in == EIO_IN_PULLUP);
    end
  end
endmodule

// *** design/eio_pkg.sv ***
// package: register map, field codes and widths of the eight-bit io port
// assumes: byte-addressed register port on the system clock
package eio_pkg;
  localparam int EIO_PINS = 8;
  localparam int EIO_AW = 16;
  localparam logic [15:0] EIO_ADR_LEVEL = 16'hF268;
  localparam logic [15:0] EIO_ADR_DIR = 16'hF269;
  localparam logic [15:0] EIO_ADR_STYLE_LO = 16'hF26A;
  localparam logic [15:0] EIO_ADR_STYLE_HI = 16'hF26B;
  localparam logic [7:0] EIO_RST_LEVEL = 8'h00;
  localparam logic [7:0] EIO_RST_DIR = 8'h00;
  localparam logic [7:0] EIO_RST_STYLE = 8'h00;
  localparam logic [7:0] EIO_RD_UNMAPPED = 8'h00;
  // direction bit values
  localparam logic EIO_DIR_OUT = 1'b0;
  localparam logic EIO_DIR_IN = 1'b1;
  // two-bit style code {high, low}
  typedef enum logic [1:0] {
    EIO_STY_HIZ = 2'b00,
    EIO_STY_PCH = 2'b01,
    EIO_STY_NCH = 2'b10,
    EIO_STY_CMOS = 2'b11
  } eio_style_t;
  // input meaning of the same codes
  localparam logic [1:0] EIO_IN_PULLDN = 2'b01;
  localparam logic [1:0] EIO_IN_PULLUP = 2'b10;
endpackage

// *** design/eio_port.sv ***
// file: top of the eight-bit general purpose io port with its four
// byte registers and the pin drive logic
// assumes: single 25 MHz clock, byte/word register port, pad outside
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
module eio_port #(
  parameter int PINS = eio_pkg::EIO_PINS
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic [eio_pkg::EIO_AW-1:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic word_in,
  output logic [15:0] rdata_out,
  input wire logic [PINS-1:0] seg_share_sel_in,
  input wire logic [PINS-1:0] lcd_segment_in,
  input wire logic [PINS-1:0] port_pins_in,
  output logic [PINS-1:0] port_pins_out,
  output logic [PINS-1:0] port_pins_oe_out,
  output logic [PINS-1:0] pull_up_out,
  output logic [PINS-1:0] pull_dn_out
);
  import eio_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [PINS-1:0] level_bits;
    logic [PINS-1:0] direction_bits;
    logic [PINS-1:0] style_code_low;
    logic [PINS-1:0] style_code_high;
    logic [15:0] rdata;
  } eio_st_t;

  eio_st_t st_ff;
  eio_st_t nxt_st;
  logic [PINS-1:0] pin_sync;
  logic [PINS-1:0] level_view;

  // ************************************************************
  // pin input synchronisers and pad decode
  // ************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi++)
    begin : g_pin
      // one synchroniser per pin
      eio_sync u_sync (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .async_in(port_pins_in[gi]),
        .level_out(pin_sync[gi])
      );
      // pad decode of bit gi
      eio_pad_ctl u_pad (
        .dir_in(st_ff.direction_bits[gi]),
        .style_in({st_ff.style_code_high[gi], st_ff.style_code_low[gi]}),
        .level_in(st_ff.level_bits[gi]),
        .seg_sel_in(seg_share_sel_in[gi]),
        .seg_val_in(lcd_segment_in[gi]),
        .pin_out(port_pins_out[gi]),
        .pin_oe_out(port_pins_oe_out[gi]),
        .pull_up_out(pull_up_out[gi]),
        .pull_dn_out(pull_dn_out[gi])
      );
    end
  endgenerate

  // ************************************************************
  // register access
  // ************************************************************
  // read view: inputs show pin, outputs show latch
  assign level_view = (st_ff.direction_bits & pin_sync) |
                      (~st_ff.direction_bits & st_ff.level_bits);

  // writes and registered read data
  always_comb
  begin
    nxt_st = st_ff;
    if (wr_in)
    begin
      case (addr_in)
        EIO_ADR_LEVEL: nxt_st.level_bits = wdata_in[7:0];
        EIO_ADR_DIR: nxt_st.direction_bits = wdata_in[7:0];
        EIO_ADR_STYLE_LO:
        begin
          nxt_st.style_code_low = wdata_in[7:0];
          if (word_in)
          begin
            nxt_st.style_code_high = wdata_in[15:8];
          end
        end
        EIO_ADR_STYLE_HI: nxt_st.style_code_high = wdata_in[7:0];
        default: nxt_st = st_ff;
      endcase
    end
    nxt_st.rdata = {8'h00, EIO_RD_UNMAPPED};
    if (rd_in)
    begin
      case (addr_in)
        EIO_ADR_LEVEL: nxt_st.rdata = {8'h00, level_view};
        EIO_ADR_DIR: nxt_st.rdata = {8'h00, st_ff.direction_bits};
        EIO_ADR_STYLE_LO:
        begin
          if (word_in)
          begin
            nxt_st.rdata = {st_ff.style_code_high, st_ff.style_code_low};
          end
          else
          begin
            nxt_st.rdata = {8'h00, st_ff.style_code_low};
          end
        end
        EIO_ADR_STYLE_HI: nxt_st.rdata = {8'h00, st_ff.style_code_high};
        default: nxt_st.rdata = {8'h00, EIO_RD_UNMAPPED};
      endcase
    end
  end

  // state register with reset values
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      st_ff.level_bits <= EIO_RST_LEVEL;
      st_ff.direction_bits <= EIO_RST_DIR;
      st_ff.style_code_low <= EIO_RST_STYLE;
      st_ff.style_code_high <= EIO_RST_STYLE;
      st_ff.rdata <= 16'h0000;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign rdata_out = st_ff.rdata;

  // ************************************************************
  // assertions
  // ************************************************************
  sequence s_wr_level;
    wr_in && addr_in == EIO_ADR_LEVEL;
  endsequence

  property p_level_store;
    @(posedge clk_in) disable iff (srst_in)
    s_wr_level |=> st_ff.level_bits == $past(wdata_in[7:0]);
  endproperty
  a_level_store: assert property (p_level_store)
    else $error("level write not stored");

  sequence s_rd_level;
    rd_in && addr_in == EIO_ADR_LEVEL;
  endsequence

  property p_out_readback;
    @(posedge clk_in) disable iff (srst_in)
    s_rd_level |=> (rdata_out[PINS-1:0] & ~$past(st_ff.direction_bits)) ==
      ($past(st_ff.level_bits) & ~$past(st_ff.direction_bits));
  endproperty
  a_out_readback: assert property (p_out_readback)
    else $error("output readback wrong");

  property p_in_read;
    @(posedge clk_in) disable iff (srst_in)
    s_rd_level |=> (rdata_out[PINS-1:0] & $past(st_ff.direction_bits)) ==
      ($past(pin_sync) & $past(st_ff.direction_bits));
  endproperty
  a_in_read: assert property (p_in_read)
    else $error("input read not pin level");

  property p_word_write;
    @(posedge clk_in) disable iff (srst_in)
    (wr_in && word_in && addr_in == EIO_ADR_STYLE_LO)
    |=> {st_ff.style_code_high, st_ff.style_code_low} == $past(wdata_in);
  endproperty
  a_word_write: assert property (p_word_write)
    else $error("style word write wrong");

  property p_dir_store;
    @(posedge clk_in) disable iff (srst_in)
    (wr_in && addr_in == EIO_ADR_DIR)
    |=> st_ff.direction_bits == $past(wdata_in[7:0]);
  endproperty
  a_dir_store: assert property (p_dir_store)
    else $error("direction write not stored");

  property p_cmos_drive;
    @(posedge clk_in) disable iff (srst_in)
    (!seg_share_sel_in[0] && !st_ff.direction_bits[0] &&
     st_ff.style_code_high[0] && st_ff.style_code_low[0])
    |-> port_pins_oe_out[0] && port_pins_out[0] == st_ff.level_bits[0];
  endproperty
  a_cmos_drive: assert property (p_cmos_drive)
    else $error("cmos pin not driven");

  property p_input_nodrive;
    @(posedge clk_in) disable iff (srst_in)
    (!seg_share_sel_in[1] && st_ff.direction_bits[1])
    |-> !port_pins_oe_out[1];
  endproperty
  a_input_nodrive: assert property (p_input_nodrive)
    else $error("input pin driven");

  property p_hiz_out;
    @(posedge clk_in) disable iff (srst_in)
    (!seg_share_sel_in[2] && !st_ff.direction_bits[2] &&
     !st_ff.style_code_high[2] && !st_ff.style_code_low[2])
    |-> !port_pins_oe_out[2];
  endproperty
  a_hiz_out: assert property (p_hiz_out)
    else $error("hiz output driven");

  property p_pullup;
    @(posedge clk_in) disable iff (srst_in)
    (!seg_share_sel_in[3] && st_ff.direction_bits[3] &&
     st_ff.style_code_high[3] && !st_ff.style_code_low[3])
    |-> pull_up_out[3] && !pull_dn_out[3];
  endproperty
  a_pullup: assert property (p_pullup)
    else $error("pull-up not selected");

  property p_seg_owns;
    @(posedge clk_in) disable iff (srst_in)
    seg_share_sel_in[4]
    |-> port_pins_oe_out[4] && port_pins_out[4] == lcd_segment_in[4];
  endproperty
  a_seg_owns: assert property (p_seg_owns)
    else $error("segment does not own pin");

  // ************************************************************
  // assertions on reset, style bytes and pad decode
  // ************************************************************
  sequence s_rst_seen;
    $past(srst_in);
  endsequence

  property p_reset_clear;
    @(posedge clk_in)
    s_rst_seen |-> st_ff.level_bits == EIO_RST_LEVEL &&
      st_ff.direction_bits == EIO_RST_DIR &&
      st_ff.style_code_low == EIO_RST_STYLE &&
      st_ff.style_code_high == EIO_RST_STYLE &&
      rdata_out == 16'h0000;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("reset values wrong");

  sequence s_wr_style_hi;
    wr_in && addr_in == EIO_ADR_STYLE_HI;
  endsequence

  property p_style_hi_store;
    @(posedge clk_in) disable iff (srst_in)
    s_wr_style_hi |=> st_ff.style_code_high == $past(wdata_in[7:0]) &&
      $stable(st_ff.style_code_low);
  endproperty
  a_style_hi_store: assert property (p_style_hi_store)
    else $error("high style byte write wrong");

  sequence s_wr_style_lo_byte;
    wr_in && !word_in && addr_in == EIO_ADR_STYLE_LO;
  endsequence

  property p_style_lo_byte;
    @(posedge clk_in) disable iff (srst_in)
    s_wr_style_lo_byte |=> st_ff.style_code_low == $past(wdata_in[7:0]) &&
      $stable(st_ff.style_code_high);
  endproperty
  a_style_lo_byte: assert property (p_style_lo_byte)
    else $error("low style byte write wrong");

  // per-pin decode classes for the pad checks
  logic [PINS-1:0] cls_out;
  logic [PINS-1:0] cls_in;
  logic [PINS-1:0] cls_code_01;
  logic [PINS-1:0] cls_code_10;
  logic [PINS-1:0] cls_code_same;

  // port-owned pins split by direction and by style code
  assign cls_out = ~seg_share_sel_in & ~st_ff.direction_bits;
  assign cls_in = ~seg_share_sel_in & st_ff.direction_bits;
  assign cls_code_01 = ~st_ff.style_code_high & st_ff.style_code_low;
  assign cls_code_10 = st_ff.style_code_high & ~st_ff.style_code_low;
  assign cls_code_same = ~(st_ff.style_code_high ^ st_ff.style_code_low);

  property p_pch_drive;
    @(posedge clk_in) disable iff (srst_in)
    (cls_out & cls_code_01 & (port_pins_oe_out ^ st_ff.level_bits)) == '0;
  endproperty
  a_pch_drive: assert property (p_pch_drive)
    else $error("p-channel drive wrong");

  property p_nch_drive;
    @(posedge clk_in) disable iff (srst_in)
    (cls_out & cls_code_10 & (port_pins_oe_out ^ ~st_ff.level_bits)) == '0;
  endproperty
  a_nch_drive: assert property (p_nch_drive)
    else $error("n-channel drive wrong");

  property p_drive_level;
    @(posedge clk_in) disable iff (srst_in)
    (~seg_share_sel_in & port_pins_oe_out &
     (port_pins_out ^ st_ff.level_bits)) == '0;
  endproperty
  a_drive_level: assert property (p_drive_level)
    else $error("driven level differs from latch");

  property p_pulldown;
    @(posedge clk_in) disable iff (srst_in)
    (cls_in & cls_code_01 & (~pull_dn_out | pull_up_out)) == '0;
  endproperty
  a_pulldown: assert property (p_pulldown)
    else $error("pull-down not selected");

  property p_in_nopull;
    @(posedge clk_in) disable iff (srst_in)
    (cls_in & cls_code_same & (pull_up_out | pull_dn_out)) == '0;
  endproperty
  a_in_nopull: assert property (p_in_nopull)
    else $error("hiz input pulled");

  property p_out_nopull;
    @(posedge clk_in) disable iff (srst_in)
    (~cls_in & (pull_up_out | pull_dn_out)) == '0;
  endproperty
  a_out_nopull: assert property (p_out_nopull)
    else $error("driven pin pulled");
endmodule

// *** design/eio_sync.sv ***
// file: three-flop synchroniser for one pin, change accepted when
// the second and third stages agree
// assumes: input is asynchronous to clk_in
`timescale 1ns/1ps
module eio_sync (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic async_in,
  output logic level_out
);
  import eio_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } eio_sync_st_t;

  eio_sync_st_t st_ff;
  eio_sync_st_t nxt_st;

  // shift chain; stage one only feeds stage two
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.s1 = async_in;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    if (st_ff.s2 == st_ff.s3)
    begin
      nxt_st.lvl = st_ff.s3; // agreed level
    end
  end

  // state register
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign level_out = st_ff.lvl;

  // ************************************************************
  // assertions
  // ************************************************************
  property p_agree_take;
    @(posedge clk_in) disable iff (srst_in)
    st_ff.s2 == st_ff.s3 |=> st_ff.lvl == $past(st_ff.s3);
  endproperty
  a_agree_take: assert property (p_agree_take)
    else $error("agreed level not taken");

  property p_disagree_hold;
    @(posedge clk_in) disable iff (srst_in)
    st_ff.s2 != st_ff.s3 |=> $stable(st_ff.lvl);
  endproperty
  a_disagree_hold: assert property (p_disagree_hold)
    else $error("unsettled level taken");
endmodule

// *** sim/eio_pad_model.sv ***
// partner: wire model for the eight port pins and their pads
// assumes: bench drives a pin only where the port does not drive it
`timescale 1ns/1ps
module eio_pad_model (
  input wire logic clk_in,
  input wire logic [7:0] oe_in,
  input wire logic [7:0] out_in,
  input wire logic [7:0] up_in,
  input wire logic [7:0] dn_in,
  input wire logic [7:0] ext_en_in,
  input wire logic [7:0] ext_val_in,
  output logic [7:0] pin_out
);
  logic [7:0] float_ff = 8'h5A;
  // floating wire shows a changing pattern, never a steady level
  always @(posedge clk_in)
  begin
    float_ff <= ~float_ff;
  end
  // wire level: port drive, outside source, pull, float
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (oe_in[i])
        pin_out[i] = out_in[i];
      else if (ext_en_in[i])
        pin_out[i] = ext_val_in[i];
      else if (up_in[i])
        pin_out[i] = 1'h1;
      else if (dn_in[i])
        pin_out[i] = 1'h0;
      else
        pin_out[i] = float_ff[i];
    end
  end
endmodule

// *** sim/eio_port_tb.sv ***
// bench: self-checking test of the eight-bit io port
// assumes: pad model closes the pin loop, register port as in eio_pkg
`timescale 1ns/1ps
module eio_port_tb;
  import eio_pkg::*;
  logic clk_in = 1'h0;
  logic srst_in = 1'h1;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic word = 1'h0;
  logic [15:0] addr = 16'h0000;
  logic [15:0] wdata = 16'h0000;
  logic [7:0] ssel = 8'h00;
  logic [7:0] sval = 8'h00;
  logic [7:0] xen = 8'h00;
  logic [7:0] xval = 8'h00;
  logic [15:0] rdata;
  logic [7:0] pout, poe, pup, pdn, pin;
  logic [7:0] m_lvl, m_dir, m_lo, m_hi;
  logic [31:0] seed = 32'hE9C41DB2;
  int errors = 0;
  int comparisons = 0;

  eio_port dut (.clk_in(clk_in), .srst_in(srst_in), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .word_in(word),
    .rdata_out(rdata), .seg_share_sel_in(ssel), .lcd_segment_in(sval),
    .port_pins_in(pin), .port_pins_out(pout), .port_pins_oe_out(poe),
    .pull_up_out(pup), .pull_dn_out(pdn));
  eio_pad_model pm (.clk_in(clk_in), .oe_in(poe), .out_in(pout),
    .up_in(pup), .dn_in(pdn), .ext_en_in(xen), .ext_val_in(xval),
    .pin_out(pin));

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task stop_test;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // one-cycle write, model follows
  task wr_reg(input logic [15:0] a, input logic [15:0] d, input logic w);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    word <= w;
    wr <= 1'h1;
    @(posedge clk_in);
    wr <= 1'h0;
    if (a == EIO_ADR_LEVEL) m_lvl = d[7:0];
    if (a == EIO_ADR_DIR) m_dir = d[7:0];
    if (a == EIO_ADR_STYLE_LO) m_lo = d[7:0];
    if (a == EIO_ADR_STYLE_LO && w) m_hi = d[15:8];
    if (a == EIO_ADR_STYLE_HI) m_hi = d[7:0];
  endtask

  // one-cycle read, data taken in the cycle after the strobe
  task rd_reg(input logic [15:0] a, input logic w, output logic [15:0] d);
    @(posedge clk_in);
    addr <= a;
    word <= w;
    rd <= 1'h1;
    @(posedge clk_in);
    rd <= 1'h0;
    #1;
    d = rdata;
  endtask

  task rchk(input logic [15:0] a, input logic w, input logic [15:0] e);
    logic [15:0] d;
    rd_reg(a, w, d);
    chk(d, e);
  endtask

  // pins and level read against the model
  task check_all;
    logic [15:0] d;
    logic [7:0] eo, eq, eu, ed, ep, mk, er, rm;
    logic [1:0] c;
    #1;
    for (int i = 0; i < 8; i++)
    begin
      c = {m_hi[i], m_lo[i]};
      eu[i] = m_dir[i] && !ssel[i] && c == EIO_IN_PULLUP;
      ed[i] = m_dir[i] && !ssel[i] && c == EIO_IN_PULLDN;
      eq[i] = ssel[i] ? sval[i] : m_lvl[i];
      eo[i] = ssel[i] || (!m_dir[i] && (c == EIO_STY_CMOS
        || (c == EIO_STY_PCH && m_lvl[i])
        || (c == EIO_STY_NCH && !m_lvl[i])));
      ep[i] = eo[i] ? eq[i] : xen[i] ? xval[i] : eu[i];
      mk[i] = eo[i] | xen[i] | eu[i] | ed[i];
      er[i] = m_dir[i] ? ep[i] : m_lvl[i];
      rm[i] = m_dir[i] ? mk[i] : 1'h1;
    end
    chk({pup, pdn}, {eu, ed});
    chk({poe, pout & eo}, {eo, eq & eo});
    rd_reg(EIO_ADR_LEVEL, 1'h0, d);
    chk(d & {8'h00, rm}, {8'h00, er & rm});
  endtask

  // ****************************************
  // clock, watchdog and test sequence
  // ****************************************
  initial
  begin
    forever #20 clk_in = ~clk_in;
  end

  initial
  begin
    #1000000;
    errors++;
    stop_test();
  end

  initial
  begin
    logic [31:0] r, q;
    {m_lvl, m_dir, m_lo, m_hi} = 32'h00000000;
    repeat (2) @(posedge clk_in);
    srst_in <= 1'h0;
    // reset values and unmapped places
    rchk(EIO_ADR_LEVEL, 1'h0, 16'h0000);
    rchk(EIO_ADR_DIR, 1'h0, 16'h0000);
    rchk(EIO_ADR_STYLE_LO, 1'h1, 16'h0000);
    rchk(EIO_ADR_STYLE_HI, 1'h0, 16'h0000);
    wr_reg(16'hF26C, 16'h00FF, 1'h0);
    rchk(16'hF26C, 1'h0, 16'h0000);
    rchk(16'hF267, 1'h0, 16'h0000);
    check_all();
    $display("test reset done");
    // byte and word access of the style pair
    wr_reg(EIO_ADR_STYLE_HI, 16'h00A5, 1'h0);
    rchk(EIO_ADR_STYLE_LO, 1'h1, 16'hA500);
    wr_reg(EIO_ADR_STYLE_LO, 16'h3CC3, 1'h1);
    rchk(EIO_ADR_STYLE_HI, 1'h0, 16'h003C);
    rchk(EIO_ADR_STYLE_LO, 1'h0, 16'h00C3);
    $display("test style access done");
    // random configurations, segment sharing and outside levels
    for (int n = 0; n < 60; n++)
    begin
      r = rnd();
      @(posedge clk_in);
      ssel <= r[7:0] & r[15:8];
      sval <= r[23:16];
      q = rnd();
      wr_reg(EIO_ADR_LEVEL, {8'h00, q[31:24]}, 1'h0);
      wr_reg(EIO_ADR_DIR, {8'h00, r[31:24]}, 1'h0);
      r = rnd();
      if (r[0])
        wr_reg(EIO_ADR_STYLE_LO, r[23:8], 1'h1);
      else
      begin
        wr_reg(EIO_ADR_STYLE_LO, {8'h00, r[15:8]}, 1'h0);
        wr_reg(EIO_ADR_STYLE_HI, {8'h00, r[23:16]}, 1'h0);
      end
      r = rnd();
      xen <= m_dir & ~ssel & r[7:0];
      xval <= r[15:8];
      repeat (6) @(posedge clk_in);
      check_all();
      rchk(EIO_ADR_DIR, 1'h0, {8'h00, m_dir});
      rchk(EIO_ADR_STYLE_LO, 1'h1, {m_hi, m_lo});
    end
    $display("test random configurations done");
    // reset in mid-run brings every register back to zero
    @(posedge clk_in);
    srst_in <= 1'h1;
    xen <= 8'h00;
    repeat (2) @(posedge clk_in);
    srst_in <= 1'h0;
    {m_lvl, m_dir, m_lo, m_hi} = 32'h00000000;
    rchk(EIO_ADR_STYLE_LO, 1'h1, 16'h0000);
    rchk(EIO_ADR_DIR, 1'h0, 16'h0000);
    check_all();
    $display("test mid-run reset done");
    stop_test();
  end
endmodule
